// file: uefc_top.sv
// Enhanced feature and flow control logic of one serial channel
`timescale 1ns/100ps
// Notes on behaviour
// - Transmit select 00 none, 10 first, 01 second, 11 both pairs.
// - Receive select 00 off, 10 compare first, 01 compare second pair.
// - Receive 11 with transmit 10/01 accepts either character.
// - Receive 11 with transmit 11/00 needs first then second.
// - All four flow select bits are zero after reset.
// - Enhanced bits written only while enhanced write enable is set.
// - Reset clears gated enhanced bits and fractional divisor.
// - Special detect compares with second pause char, sets status bit 4.
// - First pair compare: flow control and special detect both work.
// - Second pair compare: second pause char dropped, two flags raised.
// - Auto request-to-send goes high at next higher trigger level.
// - Auto request-to-send goes low below next lower trigger level.
// - Auto mode needs host assertion; else pin follows control bit.
// - Auto clear-to-send high stops transmit, low resumes it.
// - Four host read/write flow character registers.
// - Divisor latch loads 0x00/0x01 at power-up, kept on reset.
// - Reset values of status, scratch and control registers.
// - Modem status reset: deltas clear, upper bits inverted inputs.
// - Dual modes send or match two consecutive characters.
// - Transmitter finishes current character before halting.
module uefc_top
  import uefc_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  output logic O_FIFO_PUSH,
  output logic [7:0] O_FIFO_DATA,
  input wire logic [LVL_W-1:0] I_FIFO_LEVEL,
  input wire logic I_FIFO_EMPTY,
  output logic O_FLOW_VALID,
  output logic [7:0] O_FLOW_DATA,
  input wire logic I_FLOW_READY,
  input wire logic I_TX_BUSY,
  output logic O_TX_HOLD,
  input wire logic I_TX_SERIAL,
  output logic O_TX,
  input wire logic I_TX_READY,
  input wire logic [7:0] I_LINE_STATUS,
  input wire logic I_CTS_N,
  input wire logic I_DSR_N,
  input wire logic I_RI_N,
  input wire logic I_CD_N,
  output logic O_RTS_N,
  output logic O_DTR_N,
  output logic O_GENERAL_OUTPUT_TWO_N,
  output logic O_RECEIVE_READY_N,
  output logic O_TRANSMIT_READY_N,
  output logic O_INT
);
  logic [7:0] interrupt_enable_reg, fifo_control_reg, line_control_reg, modem_control_reg, scratch_reg, alternate_function_reg, fractional_divisor_reg, enhanced_feature_control, line_status_reg;
  logic [7:0] resume_char_first, resume_char_second, pause_char_first, pause_char_second;
  logic [7:0] dll = RST_DLL;
  logic [7:0] divisor_high_reg = RST_DLM;
  logic [1:0] isr_hi;
  logic [3:0] msr_delta, modem_prev, modem_n;
  logic paused, sent_pause, rts_hold, flow_is_pause;
  uefc_flow_state_type state, next_state;
  uefc_match_mode_type match_mode;
  uefc_char_type rx_char;
  logic pause_hit, resume_hit;

  // Register decode
  wire enh = enhanced_feature_control[EFR_ENH];
  wire wr_ier = I_WR && I_ADDR == IDX_IER;
  wire wr_isr = I_WR && I_ADDR == IDX_ISR;
  wire wr_fcr = I_WR && I_ADDR == IDX_FCR;
  wire wr_lcr = I_WR && I_ADDR == IDX_LCR;
  wire wr_mcr = I_WR && I_ADDR == IDX_MCR;
  wire wr_spr = I_WR && I_ADDR == IDX_SPR;
  wire wr_dll = I_WR && I_ADDR == IDX_DLL;
  wire wr_dlm = I_WR && I_ADDR == IDX_DLM;
  wire wr_dld = I_WR && I_ADDR == IDX_DLD;
  wire wr_afr = I_WR && I_ADDR == IDX_AFR;
  wire wr_efr = I_WR && I_ADDR == IDX_EFR;
  wire wr_resume_char_first = I_WR && I_ADDR == IDX_RESUME_CHAR_FIRST;
  wire wr_resume_char_second = I_WR && I_ADDR == IDX_RESUME_CHAR_SECOND;
  wire wr_pause_char_first = I_WR && I_ADDR == IDX_PAUSE_CHAR_FIRST;
  wire wr_pause_char_second = I_WR && I_ADDR == IDX_PAUSE_CHAR_SECOND;
  wire rd_msr = I_RD && I_ADDR == IDX_MSR;
  wire [1:0] tx_sel = enhanced_feature_control[3:2];
  wire [1:0] rx_sel = enhanced_feature_control[1:0];

  // Trigger thresholds around the selected level
  wire [1:0] trig_idx = fifo_control_reg[7:6];
  wire [1:0] up_idx = trig_idx == 2'h3 ? 2'h3 : trig_idx + 2'h1;
  wire [1:0] lo_idx = trig_idx == 2'h0 ? 2'h0 : trig_idx - 2'h1;
  wire [4:0] upper = trig_level(up_idx);
  wire [4:0] lower = trig_level(lo_idx);
  wire rx_trig = I_FIFO_LEVEL >= trig_level(trig_idx);

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      interrupt_enable_reg <= RST_ZERO;
      fifo_control_reg <= RST_ZERO;
      line_control_reg <= RST_ZERO;
      modem_control_reg <= RST_ZERO;
      scratch_reg <= RST_SPR;
      alternate_function_reg <= RST_ZERO;
      fractional_divisor_reg <= RST_ZERO;
      enhanced_feature_control <= RST_ZERO;
    end else begin
      if (wr_ier) interrupt_enable_reg <= enh_merge(interrupt_enable_reg, I_WDATA, IER_ENH_MASK, enh);
      if (wr_fcr) fifo_control_reg <= enh_merge(fifo_control_reg, I_WDATA, FCR_ENH_MASK, enh);
      if (wr_mcr) modem_control_reg <= enh_merge(modem_control_reg, I_WDATA, MCR_ENH_MASK, enh);
      if (wr_dld) fractional_divisor_reg <= enh_merge(fractional_divisor_reg, I_WDATA, DLD_ENH_MASK, enh);
      if (wr_lcr) line_control_reg <= I_WDATA;
      if (wr_spr) scratch_reg <= I_WDATA;
      if (wr_afr) alternate_function_reg <= I_WDATA;
      if (wr_efr) enhanced_feature_control <= I_WDATA;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      resume_char_first <= RST_ZERO;
      resume_char_second <= RST_ZERO;
      pause_char_first <= RST_ZERO;
      pause_char_second <= RST_ZERO;
    end else begin
      if (wr_resume_char_first) resume_char_first <= I_WDATA;
      if (wr_resume_char_second) resume_char_second <= I_WDATA;
      if (wr_pause_char_first) pause_char_first <= I_WDATA;
      if (wr_pause_char_second) pause_char_second <= I_WDATA;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (wr_dll) dll <= I_WDATA;
    if (wr_dlm) divisor_high_reg <= I_WDATA;
  end

  assign match_mode = rx_sel == FLOW_NONE ? MM_OFF :
                      rx_sel == FLOW_FIRST ? MM_FIRST :
                      rx_sel == FLOW_SECOND ? MM_SECOND :
                      (tx_sel == FLOW_FIRST || tx_sel == FLOW_SECOND) ?
                      MM_EITHER : MM_SEQ;
  assign rx_char = '{valid: I_RX_VALID, data: I_RX_DATA};

  uefc_seq_match u_pause_match (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_mode(match_mode),
    .i_char(rx_char),
    .i_first(pause_char_first),
    .i_second(pause_char_second),
    .o_hit(pause_hit)
  );

  uefc_seq_match u_resume_match (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_mode(match_mode),
    .i_char(rx_char),
    .i_first(resume_char_first),
    .i_second(resume_char_second),
    .o_hit(resume_hit)
  );

  wire spec_hit = enhanced_feature_control[EFR_SPEC] && I_RX_VALID && I_RX_DATA == pause_char_second;
  // Single-mode flow characters stay out of the FIFO
  wire flow_hit = (pause_hit || resume_hit) && match_mode != MM_SEQ;
  wire push_now = I_RX_VALID && !flow_hit;
  // Status flags, set wins over write
  wire [1:0] next_isr_hi = (wr_isr && enh ? I_WDATA[5:4] : isr_hi) |
                           {pause_hit, spec_hit};
  wire int_src = ((|isr_hi) && interrupt_enable_reg[IER_SPEC]) || (rx_trig && interrupt_enable_reg[IER_RX]);
  wire [7:0] isr_rd = {2'h0, isr_hi, 1'b0,
                       rx_trig && interrupt_enable_reg[IER_RX], 1'b0, !O_INT};

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      isr_hi <= 2'h0;
      O_INT <= 1'b0;
      O_FIFO_PUSH <= 1'b0;
      O_FIFO_DATA <= RST_ZERO;
    end else begin
      isr_hi <= next_isr_hi;
      O_INT <= int_src;
      O_FIFO_PUSH <= push_now;
      if (push_now) O_FIFO_DATA <= I_RX_DATA;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST || match_mode == MM_OFF) begin
      paused <= 1'b0;
    end else if (pause_hit) begin
      paused <= 1'b1;
    end else if (resume_hit) begin
      paused <= 1'b0;
    end
  end

  wire next_hold = (enhanced_feature_control[EFR_ACTS] && modem_n[0]) || paused;
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_TX_HOLD <= 1'b0;
    end else if (!I_TX_BUSY) begin
      O_TX_HOLD <= next_hold;
    end
  end

  wire flow_on = tx_sel != FLOW_NONE;
  wire start_pause = flow_on && !sent_pause && I_FIFO_LEVEL >= upper;
  wire start_resume = flow_on && sent_pause && I_FIFO_LEVEL < lower;
  wire pause_next = state == FS_IDLE ? start_pause : flow_is_pause;
  wire [7:0] first_char = tx_sel == FLOW_SECOND ?
                          (pause_next ? pause_char_second : resume_char_second) :
                          (pause_next ? pause_char_first : resume_char_first);
  wire [7:0] second_char = pause_next ? pause_char_second : resume_char_second;
  wire flow_done = I_FLOW_READY && (state == FS_SECOND ||
                   (state == FS_FIRST && tx_sel != FLOW_BOTH));
  assign O_FLOW_VALID = state != FS_IDLE;

  always_comb begin
    next_state = state;
    unique case (state)
      FS_IDLE: begin
        if (start_pause || start_resume) next_state = FS_FIRST;
      end
      FS_FIRST: begin
        if (I_FLOW_READY) begin
          next_state = tx_sel == FLOW_BOTH ? FS_SECOND : FS_IDLE;
        end
      end
      FS_SECOND: begin
        if (I_FLOW_READY) next_state = FS_IDLE;
      end
      default: next_state = FS_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      state <= FS_IDLE;
      flow_is_pause <= 1'b0;
      sent_pause <= 1'b0;
      O_FLOW_DATA <= RST_ZERO;
    end else begin
      state <= next_state;
      flow_is_pause <= pause_next;
      O_FLOW_DATA <= next_state == FS_SECOND ? second_char : first_char;
      if (!flow_on) sent_pause <= 1'b0;
      else if (flow_done) sent_pause <= flow_is_pause;
    end
  end

  wire auto_on = enhanced_feature_control[EFR_ARTS] && modem_control_reg[MCR_RTS];
  wire next_rts_hold = I_FIFO_LEVEL >= upper ? 1'b1 :
                       I_FIFO_LEVEL < lower ? 1'b0 : rts_hold;

  uefc_sync2 #(.W(4)) u_modem_sync (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_d({I_CD_N, I_RI_N, I_DSR_N, I_CTS_N}),
    .o_q(modem_n)
  );

  // Modem change flags, set wins over read clear
  wire [3:0] modem_chg = {modem_prev[3] ^ modem_n[3],
                          !modem_prev[2] && modem_n[2],
                          modem_prev[1:0] ^ modem_n[1:0]};
  wire [7:0] msr_rd = {~modem_n, msr_delta};

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      rts_hold <= 1'b0;
      O_RTS_N <= 1'b1;
      O_DTR_N <= 1'b1;
      O_GENERAL_OUTPUT_TWO_N <= 1'b1;
      O_RECEIVE_READY_N <= 1'b1;
      O_TRANSMIT_READY_N <= 1'b0;
      O_TX <= 1'b1;
      msr_delta <= 4'h0;
      modem_prev <= modem_n;
      line_status_reg <= RST_LSR;
    end else begin
      rts_hold <= next_rts_hold;
      O_RTS_N <= auto_on ? next_rts_hold : !modem_control_reg[MCR_RTS];
      O_DTR_N <= !modem_control_reg[MCR_DTR];
      O_GENERAL_OUTPUT_TWO_N <= !modem_control_reg[MCR_OP2];
      O_RECEIVE_READY_N <= I_FIFO_EMPTY;
      O_TRANSMIT_READY_N <= !I_TX_READY;
      O_TX <= I_TX_SERIAL;
      msr_delta <= (rd_msr ? 4'h0 : msr_delta) | modem_chg;
      modem_prev <= modem_n;
      line_status_reg <= I_LINE_STATUS;
    end
  end

  wire [7:0] rd_mux = I_ADDR == IDX_IER ? interrupt_enable_reg :
                      I_ADDR == IDX_ISR ? isr_rd :
                      I_ADDR == IDX_FCR ? fifo_control_reg :
                      I_ADDR == IDX_LCR ? line_control_reg :
                      I_ADDR == IDX_MCR ? modem_control_reg :
                      I_ADDR == IDX_LSR ? line_status_reg :
                      I_ADDR == IDX_MSR ? msr_rd :
                      I_ADDR == IDX_SPR ? scratch_reg :
                      I_ADDR == IDX_DLL ? dll :
                      I_ADDR == IDX_DLM ? divisor_high_reg :
                      I_ADDR == IDX_DLD ? fractional_divisor_reg :
                      I_ADDR == IDX_AFR ? alternate_function_reg :
                      I_ADDR == IDX_EFR ? enhanced_feature_control :
                      I_ADDR == IDX_RESUME_CHAR_FIRST ? resume_char_first :
                      I_ADDR == IDX_RESUME_CHAR_SECOND ? resume_char_second :
                      I_ADDR == IDX_PAUSE_CHAR_FIRST ? pause_char_first :
                      I_ADDR == IDX_PAUSE_CHAR_SECOND ? pause_char_second : RST_ZERO;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) O_RDATA <= RST_ZERO;
    else O_RDATA <= I_RD ? rd_mux : RST_ZERO;
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);

  property p_enh_lock;
    I_WR && I_ADDR == IDX_IER && !enh |=> interrupt_enable_reg[7:4] == $past(interrupt_enable_reg[7:4]);
  endproperty
  a_enh_lock: assert property (p_enh_lock)
    else $error("enhanced bits changed while locked");
  property p_spec_flag;
    enhanced_feature_control[EFR_SPEC] && I_RX_VALID && I_RX_DATA == pause_char_second |=> isr_hi[0];
  endproperty
  a_spec_flag: assert property (p_spec_flag)
    else $error("special character flag not set");
  property p_second_drop;
    enhanced_feature_control[EFR_SPEC] && rx_sel == FLOW_SECOND && I_RX_VALID &&
      I_RX_DATA == pause_char_second |=> !O_FIFO_PUSH && isr_hi == 2'h3;
  endproperty
  a_second_drop: assert property (p_second_drop)
    else $error("second pause character mishandled");
  property p_rts_high;
    auto_on && I_FIFO_LEVEL >= upper |=> O_RTS_N;
  endproperty
  a_rts_high: assert property (p_rts_high)
    else $error("request-to-send not raised at upper level");
  property p_rts_low;
    auto_on && I_FIFO_LEVEL < lower |=> !O_RTS_N;
  endproperty
  a_rts_low: assert property (p_rts_low)
    else $error("request-to-send not lowered below lower level");
  property p_rts_manual;
    !auto_on |=> O_RTS_N == !$past(modem_control_reg[MCR_RTS]);
  endproperty
  a_rts_manual: assert property (p_rts_manual)
    else $error("request-to-send does not follow control bit");
  property p_cts_stop;
    enhanced_feature_control[EFR_ACTS] && modem_n[0] && !I_TX_BUSY |=> O_TX_HOLD;
  endproperty
  a_cts_stop: assert property (p_cts_stop)
    else $error("transmit not held on clear-to-send high");
  property p_busy_keep;
    I_TX_BUSY |=> $stable(O_TX_HOLD);
  endproperty
  a_busy_keep: assert property (p_busy_keep)
    else $error("hold changed during a character");
  property p_reset_vals;
    $fell(I_SYS_RST) |-> line_status_reg == RST_LSR && scratch_reg == RST_SPR &&
      enhanced_feature_control == RST_ZERO && isr_rd == 8'h01 && O_TX && O_RTS_N;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");
  property p_pause_second;
    state == FS_IDLE && start_pause && tx_sel == FLOW_SECOND
      |=> O_FLOW_VALID && O_FLOW_DATA == pause_char_second;
  endproperty
  a_pause_second: assert property (p_pause_second)
    else $error("wrong pause character sent");
  c_spec: cover property (spec_hit ##1 O_INT);
  c_pair: cover property (state == FS_FIRST ##1 state == FS_SECOND);
  c_pause: cover property (pause_hit ##[1:20] O_TX_HOLD);
  c_rts: cover property (auto_on && $rose(O_RTS_N));
endmodule // uefc_top

// file: uefc_pkg.sv
// Constants and types of the enhanced flow control block
package uefc_pkg;
  localparam int ADDR_W = 5;
  localparam int LVL_W = 5;
  localparam logic [4:0] IDX_IER = 5'h00;
  localparam logic [4:0] IDX_ISR = 5'h01;
  localparam logic [4:0] IDX_FCR = 5'h02;
  localparam logic [4:0] IDX_LCR = 5'h03;
  localparam logic [4:0] IDX_MCR = 5'h04;
  localparam logic [4:0] IDX_LSR = 5'h05;
  localparam logic [4:0] IDX_MSR = 5'h06;
  localparam logic [4:0] IDX_SPR = 5'h07;
  localparam logic [4:0] IDX_DLL = 5'h08;
  localparam logic [4:0] IDX_DLM = 5'h09;
  localparam logic [4:0] IDX_DLD = 5'h0a;
  localparam logic [4:0] IDX_AFR = 5'h0b;
  localparam logic [4:0] IDX_EFR = 5'h0c;
  localparam logic [4:0] IDX_RESUME_CHAR_FIRST = 5'h0d;
  localparam logic [4:0] IDX_RESUME_CHAR_SECOND = 5'h0e;
  localparam logic [4:0] IDX_PAUSE_CHAR_FIRST = 5'h0f;
  localparam logic [4:0] IDX_PAUSE_CHAR_SECOND = 5'h10;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LSR = 8'h60;
  localparam logic [7:0] RST_SPR = 8'hff;
  localparam logic [7:0] RST_DLL = 8'h01;
  localparam logic [7:0] RST_DLM = 8'h00;
  localparam int EFR_ENH = 4;
  localparam int EFR_SPEC = 5;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OP2 = 3;
  localparam int IER_RX = 0;
  localparam int IER_SPEC = 5;
  localparam logic [7:0] IER_ENH_MASK = 8'hf0;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'he0;
  localparam logic [7:0] DLD_ENH_MASK = 8'hff;
  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_FIRST = 2'h2;
  localparam logic [1:0] FLOW_SECOND = 2'h1;
  localparam logic [1:0] FLOW_BOTH = 2'h3;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;
  typedef enum logic [2:0] {
    MM_OFF, MM_FIRST, MM_SECOND, MM_EITHER, MM_SEQ
  } uefc_match_mode_type;
  typedef enum logic [1:0] {
    FS_IDLE = 2'h0, FS_FIRST = 2'h1, FS_SECOND = 2'h3
  } uefc_flow_state_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } uefc_char_type;
  function automatic logic [4:0] trig_level(input logic [1:0] idx);
    return idx == 2'h0 ? TRIG_L0 : idx == 2'h1 ? TRIG_L1 :
           idx == 2'h2 ? TRIG_L2 : TRIG_L3;
  endfunction
  // Masked bits keep their value unless enhanced writes are open
  function automatic logic [7:0] enh_merge(input logic [7:0] old,
      input logic [7:0] wd, input logic [7:0] mask, input logic en);
    return en ? wd : ((wd & ~mask) | (old & mask));
  endfunction
endpackage

// file: uefc_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module uefc_sync2 #(
  parameter int W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= {W{1'b1}};
      o_q <= {W{1'b1}};
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // uefc_sync2

// file: uefc_seq_match.sv
// Single or two-character flow character matcher
`timescale 1ns/100ps
module uefc_seq_match
  import uefc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire uefc_match_mode_type i_mode,
  input wire uefc_char_type i_char,
  input wire logic [7:0] i_first,
  input wire logic [7:0] i_second,
  output logic o_hit
);
  logic got_first;
  wire is_first = i_char.data == i_first;
  wire is_second = i_char.data == i_second;
  wire hit_either = i_mode == MM_EITHER && (is_first || is_second);
  wire hit_seq = i_mode == MM_SEQ && got_first && is_second;
  wire hit_single = (i_mode == MM_FIRST && is_first) ||
                    (i_mode == MM_SECOND && is_second);
  assign o_hit = i_char.valid && (hit_single || hit_either || hit_seq);
  always_ff @(posedge i_clk) begin
    if (i_rst || i_mode != MM_SEQ) begin
      got_first <= 1'b0;
    end else if (i_char.valid) begin
      got_first <= is_first;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_seq_order;
    i_mode == MM_SEQ && i_char.valid && is_second && !got_first |-> !o_hit;
  endproperty
  a_seq_order: assert property (p_seq_order)
    else $error("sequence hit without first character");
  property p_second_only;
    i_mode == MM_SECOND && i_char.valid && !is_second |-> !o_hit;
  endproperty
  a_second_only: assert property (p_second_only)
    else $error("second pair mode hit on other character");
endmodule // uefc_seq_match

// file: uefc_far_end.sv
// Far-end transmitter model that takes flow characters and shifts them
`timescale 1ns/100ps
module uefc_far_end (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_ready,
  output logic o_busy,
  output logic o_serial,
  output logic [7:0] o_last,
  output logic [3:0] o_count
);
  logic [9:0] shift;
  logic [3:0] bits;
  logic tick;
  // Slow mode accepts only every other cycle
  assign o_ready = !o_busy && (tick || !i_slow);
  assign o_busy = bits != 4'h0;
  // Line idles high between frames
  assign o_serial = o_busy ? shift[0] : 1'b1;
  always_ff @(posedge i_clk) begin
    tick <= i_rst ? 1'b0 : !tick;
    if (i_rst) begin
      bits <= 4'h0;
      o_count <= 4'h0;
      o_last <= 8'h00;
    end else if (i_valid && o_ready) begin
      shift <= {1'b1, i_data, 1'b0};
      bits <= 4'ha;
      o_count <= o_count + 4'h1;
      o_last <= i_data;
    end else if (o_busy) begin
      shift <= {1'b1, shift[9:1]};
      bits <= bits - 4'h1;
    end
  end
endmodule // uefc_far_end

// file: tb_top.sv
// Self-checking bench of the enhanced flow control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); \
  end \
end
module tb_top
  import uefc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rx_valid = 1'b0;
  logic cts_n = 1'b1, slow = 1'b0;
  logic [4:0] addr = 5'h00, level = 5'h00;
  logic [7:0] wdata = 8'h00, rx_data = 8'h00, rdata, fdata, flow_data, last;
  logic push, fvalid, ready, busy, hold, serial, tx, rts_n, dtr_n, op2_n;
  logic receive_ready_n_n, transmit_ready_n_n, intr;
  logic [3:0] count, n;
  int bad_count = 0, total_checks = 0, cyc = 0;
  logic [7:0] tx_mode [4] = '{8'h10, 8'h18, 8'h14, 8'h1c};
  logic [7:0] tx_pause [4] = '{8'h00, 8'h13, 8'h14, 8'h14};
  logic [7:0] tx_resume [4] = '{8'h00, 8'h11, 8'h12, 8'h12};
  logic [3:0] tx_inc [4] = '{4'h0, 4'h1, 4'h1, 4'h2};
  uefc_top u_dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data), .O_FIFO_PUSH(push),
    .O_FIFO_DATA(fdata), .I_FIFO_LEVEL(level), .I_FIFO_EMPTY(level == 5'h00),
    .O_FLOW_VALID(fvalid), .O_FLOW_DATA(flow_data), .I_FLOW_READY(ready),
    .I_TX_BUSY(busy), .O_TX_HOLD(hold), .I_TX_SERIAL(serial), .O_TX(tx),
    .I_TX_READY(1'b1), .I_LINE_STATUS(RST_LSR), .I_CTS_N(cts_n),
    .I_DSR_N(1'b1), .I_RI_N(1'b1), .I_CD_N(1'b1), .O_RTS_N(rts_n),
    .O_DTR_N(dtr_n), .O_GENERAL_OUTPUT_TWO_N(op2_n),
    .O_RECEIVE_READY_N(receive_ready_n_n), .O_TRANSMIT_READY_N(transmit_ready_n_n), .O_INT(intr));
  uefc_far_end u_far (.i_clk(clk), .i_rst(rst), .i_slow(slow),
    .i_valid(fvalid), .i_data(flow_data), .o_ready(ready), .o_busy(busy),
    .o_serial(serial), .o_last(last), .o_count(count));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      complete_run;
    end
  end
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic rxc(input logic [7:0] d, input logic p);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    #1;
    `CHK("push", p, push)
    if (p) `CHK("fdata", d, fdata)
  endtask
  task automatic setlv(input logic [4:0] v);
    @(posedge clk);
    level <= v;
    wt(3);
  endtask
  task automatic wcnt(input logic [3:0] c);
    for (int k = 0; k < 60 && count !== c; k++) @(posedge clk);
    wt(1);
    `CHK("flows", c, count)
  endtask
  task automatic mode(input logic [7:0] m);
    wreg(IDX_EFR, 8'h10); // enable kept set
    wreg(IDX_EFR, m);
  endtask
  function automatic logic [7:0] rst_val(input logic [4:0] i);
    case (i)
      IDX_ISR: return 8'h01;
      IDX_LSR: return RST_LSR;
      IDX_SPR: return RST_SPR;
      IDX_DLL: return RST_DLL;
      default: return RST_ZERO;
    endcase
  endfunction
  initial begin
    wt(4);
    rst <= 1'b0;
    wt(0);
    `CHK("pins", 7'h7c, {tx, rts_n, dtr_n, op2_n, receive_ready_n_n, transmit_ready_n_n, intr})
    for (int i = 0; i < 18; i++) rreg(5'(i), rst_val(5'(i)));
    wreg(IDX_IER, 8'hff);
    rreg(IDX_IER, 8'h0f);
    wreg(IDX_DLD, 8'haa);
    rreg(IDX_DLD, 8'h00);
    wreg(IDX_EFR, 8'h10);
    wreg(IDX_IER, 8'hff);
    rreg(IDX_IER, 8'hff);
    wreg(IDX_EFR, 8'h00);
    wreg(IDX_IER, 8'h00);
    rreg(IDX_IER, 8'hf0);
    wreg(IDX_DLL, 8'h55);
    rst <= 1'b1;
    wt(4);
    rst <= 1'b0;
    rreg(IDX_DLL, 8'h55);
    rreg(IDX_IER, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wreg(IDX_RESUME_CHAR_FIRST + 5'(i), 8'h11 + 8'(i));
      rreg(IDX_RESUME_CHAR_FIRST + 5'(i), 8'h11 + 8'(i));
    end
    mode(8'h12);
    rxc(8'h13, 1'b0);
    wt(1);
    `CHK("hold", 1'b1, hold)
    rxc(8'h41, 1'b1);
    rxc(8'h11, 1'b0);
    wt(1);
    `CHK("hold", 1'b0, hold)
    rxc(8'h14, 1'b1);
    mode(8'h11);
    rxc(8'h14, 1'b0);
    rxc(8'h13, 1'b1);
    rxc(8'h12, 1'b0);
    mode(8'h1b);
    rxc(8'h14, 1'b0);
    rxc(8'h11, 1'b0);
    rxc(8'h13, 1'b0);
    rxc(8'h12, 1'b0);
    mode(8'h1f);
    rxc(8'h13, 1'b1);
    rxc(8'h14, 1'b1);
    wt(1);
    `CHK("hold", 1'b1, hold)
    rxc(8'h11, 1'b1);
    rxc(8'h12, 1'b1);
    wt(1);
    `CHK("hold", 1'b0, hold)
    mode(8'h30);
    wreg(IDX_ISR, 8'h00);
    rxc(8'h14, 1'b1);
    rreg(IDX_ISR, 8'h11);
    mode(8'h32);
    rxc(8'h13, 1'b0);
    rxc(8'h14, 1'b1);
    rxc(8'h11, 1'b0);
    mode(8'h31);
    wreg(IDX_ISR, 8'h00);
    rxc(8'h14, 1'b0);
    rxc(8'h12, 1'b0);
    rreg(IDX_ISR, 8'h31);
    wreg(IDX_IER, 8'h20);
    wt(2);
    `CHK("int", 1'b1, intr)
    wreg(IDX_ISR, 8'h00);
    wreg(IDX_IER, 8'h00);
    rreg(IDX_ISR, 8'h01);
    wreg(IDX_MCR, 8'h0b);
    wt(2);
    `CHK("rts", 1'b0, rts_n)
    `CHK("dtr_op2", 2'b00, {dtr_n, op2_n})
    mode(8'h50);
    setlv(5'h04);
    `CHK("rts", 1'b1, rts_n)
    `CHK("receive_ready_n", 1'b0, receive_ready_n_n)
    setlv(5'h01);
    `CHK("rts", 1'b1, rts_n)
    setlv(5'h00);
    `CHK("rts", 1'b0, rts_n)
    `CHK("receive_ready_n", 1'b1, receive_ready_n_n)
    wreg(IDX_MCR, 8'h00);
    wt(2);
    `CHK("rts", 1'b1, rts_n)
    `CHK("dtr_op2", 2'b11, {dtr_n, op2_n})
    mode(8'h90);
    cts_n <= 1'b1;
    wt(5);
    `CHK("hold", 1'b1, hold)
    cts_n <= 1'b0;
    wt(5);
    `CHK("hold", 1'b0, hold)
    for (int i = 0; i < 4; i++) begin
      mode(tx_mode[i]);
      slow <= i[0];
      n = count;
      setlv(5'h04);
      if (i == 3) `CHK("fvalid", 1'b1, fvalid)
      wcnt(n + tx_inc[i]);
      if (tx_inc[i] != 4'h0) `CHK("pause", tx_pause[i], last)
      setlv(5'h00);
      wcnt(n + 2 * tx_inc[i]);
      if (tx_inc[i] != 4'h0) `CHK("resume", tx_resume[i], last)
      `CHK("fvalid", 1'b0, fvalid)
    end
    complete_run;
  end
endmodule // tb_top
